// [logic/usbgc_pkg.sv]
// Shared constants, field layouts and carrier types for the USB global control
package usbgc_pkg;

  // ---------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------
  localparam int ADDR_W    = 12;
  localparam int EP_COUNT  = 7;
  localparam int DMA_COUNT = 6;
  localparam int FRAME_W   = 11;

  // ---------------------------------------------------------------
  // Register byte offsets
  // ---------------------------------------------------------------
  localparam logic [11:0] OFS_IRQ_EN    = 12'h010;
  localparam logic [11:0] OFS_EN_CLR    = 12'h014;
  localparam logic [11:0] OFS_EN_SET    = 12'h018;
  localparam logic [11:0] OFS_EP_CTRL   = 12'h01C;
  localparam logic [11:0] OFS_FRAME     = 12'h020;
  localparam logic [11:0] OFS_EP_CFG    = 12'h100;
  localparam logic [11:0] EP_CFG_SPAN   = 12'h01C;
  localparam int          CFG_IDX_LSB   = 2;

  // ---------------------------------------------------------------
  // Enable word layout
  // ---------------------------------------------------------------
  localparam logic [31:0] IRQ_EN_MASK   = 32'h7E07_F07D;
  localparam logic [31:0] IRQ_EN_RESET  = 32'h0000_0000;
  localparam int BIT_SUSPEND     = 0;
  localparam int BIT_FRAME_START = 2;
  localparam int BIT_RESET_END   = 3;
  localparam int BIT_WAKE        = 4;
  localparam int BIT_RESUME_END  = 5;
  localparam int BIT_UPSTREAM    = 6;
  localparam int EP_IRQ_LSB      = 12;
  localparam int DMA_IRQ_LSB     = 25;

  // ---------------------------------------------------------------
  // Endpoint control, frame and configuration layouts
  // ---------------------------------------------------------------
  localparam int EPEN_LSB      = 0;
  localparam int EPRST_LSB     = 16;
  localparam int FRAME_LSB     = 3;
  localparam int FRAME_CRC_BIT = 15;
  localparam int MEMORY_ALLOCATE_BIT     = 1;
  localparam int BANKS_LSB     = 2;
  localparam int SIZE_LSB      = 4;
  localparam int DIR_BIT       = 8;
  localparam int AUTO_BANK_SWITCH_BIT    = 9;
  localparam int TYPE_LSB      = 12;

  // Field encodings
  localparam logic [1:0]  BANKS_RESERVED = 2'h3;
  localparam logic [1:0]  TYPE_CONTROL   = 2'h0;
  localparam logic [1:0]  TYPE_ISO       = 2'h1;
  localparam logic [1:0]  TYPE_BULK      = 2'h2;
  localparam logic [1:0]  TYPE_INTERRUPT = 2'h3;
  localparam logic [10:0] BANK_MIN_BYTES = 11'h008;

  // ---------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic suspend;
    logic frame_start;
    logic reset_end;
    logic wake;
    logic resume_end;
    logic upstream_resume;
  } usbgc_evt_t;

  typedef struct packed {
    logic               valid;
    logic               crc_bad;
    logic [FRAME_W-1:0] frame;
  } usbgc_sof_t;

  typedef struct packed {
    logic [1:0] transfer_type;
    logic       auto_bank_switch;
    logic       transfer_direction;
    logic [2:0] bank_size;
    logic [1:0] bank_count;
    logic       memory_allocate;
  } usbgc_cfg_t;

  typedef struct packed {
    logic [1:0]  banks;
    logic [10:0] bytes;
    logic        is_control;
  } usbgc_geom_t;

  // Register word to configuration fields
  function automatic usbgc_cfg_t usbgc_cfg_unpack(input logic [31:0] w);
    usbgc_cfg_t c;
    c.memory_allocate    = w[MEMORY_ALLOCATE_BIT];
    c.bank_count         = w[BANKS_LSB +: 2];
    c.bank_size          = w[SIZE_LSB +: 3];
    c.transfer_direction = w[DIR_BIT];
    c.auto_bank_switch   = w[AUTO_BANK_SWITCH_BIT];
    c.transfer_type      = w[TYPE_LSB +: 2];
    return c;
  endfunction : usbgc_cfg_unpack

  // Configuration fields to register word, reserved bits zero
  function automatic logic [31:0] usbgc_cfg_pack(input usbgc_cfg_t c);
    logic [31:0] w;
    w                  = '0;
    w[MEMORY_ALLOCATE_BIT]       = c.memory_allocate;
    w[BANKS_LSB +: 2]  = c.bank_count;
    w[SIZE_LSB +: 3]   = c.bank_size;
    w[DIR_BIT]         = c.transfer_direction;
    w[AUTO_BANK_SWITCH_BIT]      = c.auto_bank_switch;
    w[TYPE_LSB +: 2]   = c.transfer_type;
    return w;
  endfunction : usbgc_cfg_pack

endpackage : usbgc_pkg

// [logic/usbgc_top.sv]
// USB device global control: enables, frame capture, endpoint control
//
// How it works
// - Upstream-resume enable follows its set/clear strobes
// - Endpoint 0-6 enables change only via strobes
// - DMA 1-6 enables change only via strobes
// - Clear register clears ones, reads zero
// - Set register sets ones, reads zero
// - Bus-event enables at bits 0,2,3,4,5,6
// - Endpoints bits 12-18, DMA bits 25-30
// - Capture 11-bit frame, zero on bus reset
// - Frame updates even on corrupted SOF
// - CRC error flag with SOF, bus reset clears
// - Disabled endpoint ignores host, geometry kept
// - FIFO reset bit halts endpoint, bus-reset cleared
// - Toggle cleared only by its reset control
// - Config words at 0x100 plus 4 each
// - Bus event interrupts only while enabled
// - Size code gives 8 bytes doubled per step
// - Bank code gives 1,2,3 banks; 3 reserved
// - Type code: control, iso, bulk, interrupt
`timescale 1ns/1ns
module usbgc_top (
  input  wire logic                            core_clk,
  input  wire logic                            reset,
  input  wire logic                            psel,
  input  wire logic                            penable,
  input  wire logic                            pwrite,
  input  wire logic [usbgc_pkg::ADDR_W-1:0]    paddr,
  input  wire logic [31:0]                     pwdata,
  output logic      [31:0]                     prdata,
  output logic                                 pready,
  output logic                                 pslverr,
  input  wire usbgc_pkg::usbgc_evt_t           bus_event,
  input  wire logic [usbgc_pkg::EP_COUNT-1:0]  endpoint_irq,
  input  wire logic [usbgc_pkg::DMA_COUNT-1:0] dma_channel_irq,
  input  wire usbgc_pkg::usbgc_sof_t           sof_in,
  input  wire logic                            usb_bus_reset,
  input  wire logic [usbgc_pkg::EP_COUNT-1:0]  toggle_advance,
  input  wire logic [usbgc_pkg::EP_COUNT-1:0]  toggle_reset,
  output logic                                 usb_irq,
  output logic [usbgc_pkg::FRAME_W-1:0]        frame_count,
  output logic                                 frame_crc_error,
  output logic [usbgc_pkg::EP_COUNT-1:0]       endpoint_active,
  output logic [usbgc_pkg::EP_COUNT-1:0]       endpoint_fifo_reset,
  output logic [usbgc_pkg::EP_COUNT-1:0]       endpoint_ready,
  output logic [usbgc_pkg::EP_COUNT-1:0]       toggle_sequence,
  output usbgc_pkg::usbgc_cfg_t [usbgc_pkg::EP_COUNT-1:0] ep_cfg,
  output usbgc_pkg::usbgc_geom_t [usbgc_pkg::EP_COUNT-1:0] ep_geom
);

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  logic        setup_phase;
  logic        wr;
  logic [11:0] cfg_ofs;
  logic [2:0]  cfg_idx;
  logic        cfg_hit;
  logic [31:0] next_prdata;
  logic        next_slverr;
  logic [31:0] irq_en;
  logic [31:0] event_word;

  // Setup cycle starts a transfer; write lands at the access edge
  assign setup_phase = psel & ~penable;
  assign wr          = psel & penable & pready & pwrite & ~pslverr;

  // Endpoint configuration window, word aligned only
  assign cfg_ofs = paddr - usbgc_pkg::OFS_EP_CFG;
  assign cfg_idx = cfg_ofs[usbgc_pkg::CFG_IDX_LSB +: 3];
  assign cfg_hit = (paddr >= usbgc_pkg::OFS_EP_CFG) &&
                   (cfg_ofs < usbgc_pkg::EP_CFG_SPAN) &&
                   (cfg_ofs[1:0] == 2'h0);

  // Read data chosen during setup, registered for the access cycle
  always_comb begin
    next_prdata = '0;
    next_slverr = 1'b0;
    if (paddr == usbgc_pkg::OFS_IRQ_EN) begin
      next_prdata = irq_en;
    end else if (paddr == usbgc_pkg::OFS_EN_CLR ||
                 paddr == usbgc_pkg::OFS_EN_SET) begin
      next_prdata = '0;
    end else if (paddr == usbgc_pkg::OFS_EP_CTRL) begin
      next_prdata[usbgc_pkg::EPEN_LSB +: usbgc_pkg::EP_COUNT] =
        endpoint_active;
      next_prdata[usbgc_pkg::EPRST_LSB +: usbgc_pkg::EP_COUNT] =
        endpoint_fifo_reset;
    end else if (paddr == usbgc_pkg::OFS_FRAME) begin
      next_prdata[usbgc_pkg::FRAME_LSB +: usbgc_pkg::FRAME_W] =
        frame_count;
      next_prdata[usbgc_pkg::FRAME_CRC_BIT] = frame_crc_error;
    end else if (cfg_hit) begin
      next_prdata = usbgc_pkg::usbgc_cfg_pack(ep_cfg[cfg_idx]);
    end else begin
      next_slverr = 1'b1;
    end
  end

  // APB answer: one registered wait-free access cycle per transfer
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= '0;
    end else begin
      pready  <= setup_phase;
      pslverr <= setup_phase & next_slverr;
      prdata  <= setup_phase ? next_prdata : '0;
    end
  end

  // ---------------------------------------------------------------
  // Interrupt enables
  // ---------------------------------------------------------------
  // Flag word laid out like the enable word so one AND gates them all
  always_comb begin
    event_word = '0;
    event_word[usbgc_pkg::BIT_SUSPEND]     = bus_event.suspend;
    event_word[usbgc_pkg::BIT_FRAME_START] = bus_event.frame_start;
    event_word[usbgc_pkg::BIT_RESET_END]   = bus_event.reset_end;
    event_word[usbgc_pkg::BIT_WAKE]        = bus_event.wake;
    event_word[usbgc_pkg::BIT_RESUME_END]  = bus_event.resume_end;
    event_word[usbgc_pkg::BIT_UPSTREAM]    = bus_event.upstream_resume;
    event_word[usbgc_pkg::EP_IRQ_LSB +: usbgc_pkg::EP_COUNT] =
      endpoint_irq;
    event_word[usbgc_pkg::DMA_IRQ_LSB +: usbgc_pkg::DMA_COUNT] =
      dma_channel_irq;
  end

  // Strobe writes are the only path; zeros leave enables alone
  always_ff @(posedge core_clk) begin
    if (reset) begin
      irq_en <= usbgc_pkg::IRQ_EN_RESET;
    end else if (wr && paddr == usbgc_pkg::OFS_EN_CLR) begin
      irq_en <= irq_en & ~pwdata;
    end else if (wr && paddr == usbgc_pkg::OFS_EN_SET) begin
      irq_en <= (irq_en | pwdata) & usbgc_pkg::IRQ_EN_MASK;
    end
  end

  // Registered so the output is glitch free at the cost of a cycle
  always_ff @(posedge core_clk) begin
    if (reset) begin
      usb_irq <= 1'b0;
    end else begin
      usb_irq <= |(event_word & irq_en);
    end
  end

  // ---------------------------------------------------------------
  // Frame number capture
  // ---------------------------------------------------------------
  // Corrupt frames still update the count; the flag says so
  always_ff @(posedge core_clk) begin
    if (reset || usb_bus_reset) begin
      frame_count     <= '0;
      frame_crc_error <= 1'b0;
    end else if (sof_in.valid) begin
      frame_count     <= sof_in.frame;
      frame_crc_error <= sof_in.crc_bad;
    end
  end

  // ---------------------------------------------------------------
  // Endpoint enable and FIFO reset
  // ---------------------------------------------------------------
  // Bus reset beats a same-cycle software write to the FIFO reset bits; enables still take the write
  always_ff @(posedge core_clk) begin
    if (reset) begin
      endpoint_active     <= '0;
      endpoint_fifo_reset <= '0;
    end else begin
      if (wr && paddr == usbgc_pkg::OFS_EP_CTRL) begin
        endpoint_active <=
          pwdata[usbgc_pkg::EPEN_LSB +: usbgc_pkg::EP_COUNT];
        endpoint_fifo_reset <=
          pwdata[usbgc_pkg::EPRST_LSB +: usbgc_pkg::EP_COUNT];
      end
      if (usb_bus_reset) begin
        endpoint_fifo_reset <= '0;
      end
    end
  end

  // Host traffic accepted only when enabled and out of FIFO reset
  always_ff @(posedge core_clk) begin
    if (reset) begin
      endpoint_ready <= '0;
    end else begin
      endpoint_ready <= endpoint_active & ~endpoint_fifo_reset;
    end
  end

  // Toggle survives endpoint disable and FIFO reset on purpose
  always_ff @(posedge core_clk) begin
    if (reset) begin
      toggle_sequence <= '0;
    end else begin
      toggle_sequence <= (toggle_sequence ^ toggle_advance) &
                         ~toggle_reset;
    end
  end

  // ---------------------------------------------------------------
  // Endpoint configuration, one slice per endpoint
  // ---------------------------------------------------------------
  for (genvar ep = 0; ep < usbgc_pkg::EP_COUNT; ep++) begin : g_ep
    logic cfg_wr;
    assign cfg_wr = wr && cfg_hit && (cfg_idx == 3'(ep));

    // Disable or FIFO reset drops the automatic switch only
    always_ff @(posedge core_clk) begin
      if (reset) begin
        ep_cfg[ep] <= '0;
      end else begin
        if (usb_bus_reset) begin
          // Endpoint 0 keeps its memory layout across bus reset
          if (ep != 0) begin
            ep_cfg[ep].memory_allocate <= 1'b0;
            ep_cfg[ep].bank_count      <= '0;
            ep_cfg[ep].bank_size       <= '0;
          end
          ep_cfg[ep].transfer_direction <= 1'b0;
          ep_cfg[ep].transfer_type      <= '0;
        end else if (cfg_wr) begin
          ep_cfg[ep] <= usbgc_pkg::usbgc_cfg_unpack(pwdata);
        end
        if (usb_bus_reset || !endpoint_active[ep] ||
            endpoint_fifo_reset[ep]) begin
          ep_cfg[ep].auto_bank_switch <= 1'b0;
        end
      end
    end

    // Decoded geometry for the FIFO allocator
    always_ff @(posedge core_clk) begin
      if (reset) begin
        ep_geom[ep] <= '0;
      end else begin
        ep_geom[ep].banks <=
          (ep_cfg[ep].bank_count == usbgc_pkg::BANKS_RESERVED) ?
          2'h0 : ep_cfg[ep].bank_count + 2'h1;
        ep_geom[ep].bytes <=
          usbgc_pkg::BANK_MIN_BYTES << ep_cfg[ep].bank_size;
        ep_geom[ep].is_control <=
          ep_cfg[ep].transfer_type == usbgc_pkg::TYPE_CONTROL;
      end
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);

  sequence s_set_wr;
    wr && paddr == usbgc_pkg::OFS_EN_SET;
  endsequence

  sequence s_clr_wr;
    wr && paddr == usbgc_pkg::OFS_EN_CLR;
  endsequence

  sequence s_sof_seen;
    sof_in.valid && !usb_bus_reset;
  endsequence

  property p_en_set;
    s_set_wr |=> ((irq_en & $past(pwdata) & usbgc_pkg::IRQ_EN_MASK) ==
                  ($past(pwdata) & usbgc_pkg::IRQ_EN_MASK));
  endproperty
  a_en_set: assert property (p_en_set)
    else $error("set strobe did not raise enable");

  property p_en_clr;
    s_clr_wr |=> (irq_en & $past(pwdata)) == 32'h0000_0000;
  endproperty
  a_en_clr: assert property (p_en_clr)
    else $error("clear strobe did not drop enable");

  property p_en_hold;
    !(wr && (paddr == usbgc_pkg::OFS_EN_CLR ||
             paddr == usbgc_pkg::OFS_EN_SET)) |=> $stable(irq_en);
  endproperty
  a_en_hold: assert property (p_en_hold)
    else $error("enable changed without strobe");

  property p_wo_zero;
    psel && penable && pready && !pwrite &&
    (paddr == usbgc_pkg::OFS_EN_CLR || paddr == usbgc_pkg::OFS_EN_SET)
    |-> prdata == 32'h0000_0000;
  endproperty
  a_wo_zero: assert property (p_wo_zero)
    else $error("strobe register read not zero");

  property p_frame;
    s_sof_seen |=> frame_count == $past(sof_in.frame) &&
                   frame_crc_error == $past(sof_in.crc_bad);
  endproperty
  a_frame: assert property (p_frame)
    else $error("frame number not captured");

  property p_bus_reset;
    usb_bus_reset |=> frame_count == '0 && !frame_crc_error &&
                      endpoint_fifo_reset == '0;
  endproperty
  a_bus_reset: assert property (p_bus_reset)
    else $error("bus reset did not clear state");

  property p_irq;
    |(event_word & irq_en) |=> usb_irq;
  endproperty
  a_irq: assert property (p_irq)
    else $error("enabled event gave no interrupt");

  property p_irq_quiet;
    !(|(event_word & irq_en)) |=> !usb_irq;
  endproperty
  a_irq_quiet: assert property (p_irq_quiet)
    else $error("interrupt without enabled event");

  property p_toggle;
    toggle_advance == '0 && toggle_reset == '0 |=> $stable(toggle_sequence);
  endproperty
  a_toggle: assert property (p_toggle)
    else $error("toggle changed without control");

  property p_disable;
    endpoint_active == '0 ##1 endpoint_active == '0 |->
      ##1 endpoint_ready == '0;
  endproperty
  a_disable: assert property (p_disable)
    else $error("disabled endpoint still ready");

  property p_visible;
    s_set_wr ##1 1'b1 |-> 1'b1 ##0
      (irq_en & usbgc_pkg::IRQ_EN_MASK & $past(pwdata)) != 32'h0 ||
      ($past(pwdata) & usbgc_pkg::IRQ_EN_MASK) == 32'h0;
  endproperty
  a_visible: assert property (p_visible)
    else $error("enable not visible after write");

endmodule : usbgc_top

// [tb/testbench.sv]
// Self-checking bench for the USB device global control block
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin \
  mismatches++; $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module testbench;
  // ---------------------------------------------------------------
  // Signals and bookkeeping
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [31:0] mask;
    logic        err;
    logic [31:0] data;
  } usbgc_note_t;
  localparam logic [31:0] MASK = 32'h7E07_F07D;
  logic                   core_clk = 1'b0;
  logic                   reset, psel, penable, pwrite, pready, pslverr;
  logic [11:0]            paddr;
  logic [31:0]            pwdata, prdata, en, fv, w;
  usbgc_pkg::usbgc_evt_t  bus_event;
  logic [6:0]             endpoint_irq, tadv, trst, toggle_sequence;
  logic [6:0]             endpoint_ready, ep_act, ep_frst;
  logic [5:0]             dma_channel_irq;
  usbgc_pkg::usbgc_sof_t  sof;
  logic                   usb_bus_reset, usb_irq, frame_crc_error;
  logic [10:0]            frame_count;
  usbgc_pkg::usbgc_geom_t [6:0] ep_geom;
  usbgc_pkg::usbgc_cfg_t  [6:0] ep_cfg;
  logic [31:0]            cfgs [7];
  logic [31:0]            seed = 32'h0000_0006;
  usbgc_note_t            notes [$];
  usbgc_note_t            nt;
  int                     mismatches = 0;
  int                     checks_done = 0;

  always #5 core_clk = ~core_clk;

  usbgc_top usbgc_top_inst (.core_clk(core_clk), .reset(reset),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bus_event(bus_event), .endpoint_irq(endpoint_irq),
    .dma_channel_irq(dma_channel_irq), .sof_in(sof),
    .usb_bus_reset(usb_bus_reset), .toggle_advance(tadv),
    .toggle_reset(trst), .usb_irq(usb_irq), .frame_count(frame_count),
    .frame_crc_error(frame_crc_error), .endpoint_active(ep_act),
    .endpoint_fifo_reset(ep_frst), .endpoint_ready(endpoint_ready),
    .toggle_sequence(toggle_sequence), .ep_cfg(ep_cfg), .ep_geom(ep_geom));

  usbgc_host_model usbgc_host_model_inst (.core_clk(core_clk),
    .sof_out(sof), .bus_reset(usb_bus_reset));

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : xs

  // APB transfer; the expected answer is noted for the monitor
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, input logic [31:0] ex,
                     input logic [31:0] m, input logic er);
    @(posedge core_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    notes.push_back('{m, er, ex});
    @(posedge core_clk);
    penable <= 1'b1;
    // No bound here: a slave that never answers is the watchdog's case
    do begin
      @(posedge core_clk);
    end while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 32'h0, 1'b0);
  endtask : wr

  task automatic rd(input logic [11:0] a, input logic [31:0] ex);
    apb(1'b0, a, 32'h0, ex, 32'hFFFF_FFFF, 1'b0);
  endtask : rd

  // Drive the flag inputs in enable-word order
  task automatic set_flags(input logic [31:0] f);
    @(posedge core_clk);
    bus_event       <= {f[0], f[2], f[3], f[4], f[5], f[6]};
    endpoint_irq    <= f[18:12];
    dma_channel_irq <= f[30:25];
    repeat (3) @(posedge core_clk);
    #1;
  endtask : set_flags

  task automatic pulse_tog(input logic [6:0] adv, input logic [6:0] rs);
    @(posedge core_clk);
    tadv <= adv;
    trst <= rs;
    @(posedge core_clk);
    tadv <= 7'h00;
    trst <= 7'h00;
    repeat (2) @(posedge core_clk);
    #1;
  endtask : pulse_tog

  task automatic finish_test();
    if (mismatches == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : finish_test

  // ---------------------------------------------------------------
  // Monitor: each bus answer takes the oldest note
  // ---------------------------------------------------------------
  always @(posedge core_clk) begin
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1) begin
      if (notes.size() == 0) begin
        mismatches++;
        $display("[ERR] bus answer exp none got %h", prdata);
      end else begin
        nt = notes.pop_front();
        `CHK("prdata", nt.data & nt.mask, prdata & nt.mask)
        `CHK("pslverr", nt.err, pslverr)
      end
    end
  end

  // Hang guard, generous against a run of under a thousand cycles
  initial begin
    #400000;
    mismatches++;
    finish_test();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    {reset, psel, penable, pwrite, paddr, pwdata} = '1;
    {psel, penable} = 2'b00;
    {bus_event, endpoint_irq, dma_channel_irq, tadv, trst} = '0;
    repeat (5) @(posedge core_clk);
    reset <= 1'b0;
    // Reset values, ignored write, unmapped and unaligned places
    wr(usbgc_pkg::OFS_IRQ_EN, 32'hFFFF_FFFF);
    rd(usbgc_pkg::OFS_IRQ_EN, 32'h0);
    rd(usbgc_pkg::OFS_EP_CTRL, 32'h0);
    rd(usbgc_pkg::OFS_FRAME, 32'h0);
    for (int i = 0; i < 7; i++)
      rd(usbgc_pkg::OFS_EP_CFG + 12'(i * 4), 32'h0);
    apb(1'b0, 12'h024, 32'h0, 32'h0, 32'hFFFF_FFFF, 1'b1);
    apb(1'b1, 12'h101, 32'h1, 32'h0, 32'h0, 1'b1);
    // Random set and clear strobes
    en = 32'h0;
    for (int k = 0; k < 6; k++) begin
      w = xs();
      wr(usbgc_pkg::OFS_EN_SET, w);
      en = en | (w & MASK);
      rd(usbgc_pkg::OFS_IRQ_EN, en);
      w = xs();
      wr(usbgc_pkg::OFS_EN_CLR, w);
      en = en & ~w;
      rd(usbgc_pkg::OFS_IRQ_EN, en);
      rd(usbgc_pkg::OFS_EN_CLR, 32'h0);
      rd(usbgc_pkg::OFS_EN_SET, 32'h0);
    end
    // Walk every strobe position alone
    wr(usbgc_pkg::OFS_EN_CLR, 32'hFFFF_FFFF);
    for (int b = 0; b < 32; b++) begin
      wr(usbgc_pkg::OFS_EN_SET, 32'h1 << b);
      rd(usbgc_pkg::OFS_IRQ_EN, (32'h1 << b) & MASK);
      wr(usbgc_pkg::OFS_EN_CLR, 32'h1 << b);
      rd(usbgc_pkg::OFS_IRQ_EN, 32'h0);
    end
    // Interrupt only through enabled flags
    for (int k = 0; k < 10; k++) begin
      en = xs() & MASK;
      wr(usbgc_pkg::OFS_EN_SET, en);
      wr(usbgc_pkg::OFS_EN_CLR, ~en);
      fv = xs() & MASK;
      if (k % 2 == 1)
        fv = fv & ~en;
      set_flags(fv);
      `CHK("usb_irq", |(fv & en), usb_irq)
    end
    // Frame capture, corrupted frame, read-only write, bus reset
    for (int k = 0; k < 3; k++) begin
      w[10:0] = (k == 0) ? 11'h7FF : 11'(xs());
      usbgc_host_model_inst.send_sof(w[10:0], k == 1);
      #1;
      `CHK("frame_count", w[10:0], frame_count)
      `CHK("frame_crc_error", k == 1, frame_crc_error)
      rd(usbgc_pkg::OFS_FRAME, {16'h0, k == 1, 1'b0, w[10:0], 3'h0});
    end
    wr(usbgc_pkg::OFS_FRAME, 32'hFFFF_FFFF);
    rd(usbgc_pkg::OFS_FRAME, {18'h0, w[10:0], 3'h0});
    usbgc_host_model_inst.send_sof(11'h155, 1'b1);
    usbgc_host_model_inst.reset_bus(3);
    rd(usbgc_pkg::OFS_FRAME, 32'h0);
    // Endpoints: reset first, then release
    wr(usbgc_pkg::OFS_EP_CTRL, 32'h007F_007F);
    rd(usbgc_pkg::OFS_EP_CTRL, 32'h007F_007F);
    repeat (2) @(posedge core_clk);
    `CHK("endpoint_ready", 7'h00, endpoint_ready)
    wr(usbgc_pkg::OFS_EP_CTRL, 32'h0000_007F);
    // Configuration words and the geometry they decode to
    for (int k = 0; k < 8; k++) begin
      // Automatic switch always set so a later disable can be seen to drop it
      w = (xs() & 32'h0000_0102) | 32'h0000_0200 | (32'(k % 4) << 2);
      w = w | (32'(k) << 4);
      w = w | (32'(k % 4) << 12);
      cfgs[k % 7] = w;
      wr(usbgc_pkg::OFS_EP_CFG + 12'((k % 7) * 4), w);
      rd(usbgc_pkg::OFS_EP_CFG + 12'((k % 7) * 4), w);
      repeat (2) @(posedge core_clk);
      #1;
      `CHK("bytes", 11'h008 << k, ep_geom[k % 7].bytes)
      `CHK("banks", (k % 4 == 3) ? 2'h0 : 2'(k % 4 + 1), ep_geom[k % 7].banks)
      `CHK("control", k % 4 == 0, ep_geom[k % 7].is_control)
      `CHK("bank_size", 3'(k), ep_cfg[k % 7].bank_size)
    end
    `CHK("endpoint_ready", 7'h7F, endpoint_ready)
    // Disable endpoint 3, hold endpoint 5 in FIFO reset
    wr(usbgc_pkg::OFS_EP_CTRL, 32'h0020_0077);
    rd(usbgc_pkg::OFS_EP_CTRL, 32'h0020_0077);
    repeat (2) @(posedge core_clk);
    `CHK("endpoint_ready", 7'h57, endpoint_ready)
    `CHK("endpoint_active", 7'h77, ep_act)
    `CHK("endpoint_fifo_reset", 7'h20, ep_frst)
    `CHK("auto_switch3", 1'b0, ep_cfg[3].auto_bank_switch)
    `CHK("auto_switch5", 1'b0, ep_cfg[5].auto_bank_switch)
    `CHK("auto_switch4", 1'b1, ep_cfg[4].auto_bank_switch)
    apb(1'b0, 12'h10C, 32'h0, cfgs[3], 32'hFFFF_FDFF, 1'b0);
    apb(1'b0, 12'h114, 32'h0, cfgs[5], 32'hFFFF_FDFF, 1'b0);
    // Bus reset keeps endpoint 0 geometry only
    usbgc_host_model_inst.reset_bus(2);
    rd(usbgc_pkg::OFS_EP_CTRL, 32'h0000_0077);
    `CHK("endpoint_fifo_reset", 7'h00, ep_frst)
    rd(usbgc_pkg::OFS_EP_CFG, cfgs[0] & 32'h0000_007E);
    for (int i = 1; i < 7; i++)
      rd(usbgc_pkg::OFS_EP_CFG + 12'(i * 4), 32'h0);
    // Toggle sequence survives FIFO reset; its own reset wins
    pulse_tog(7'h7F, 7'h00);
    `CHK("toggle", 7'h7F, toggle_sequence)
    wr(usbgc_pkg::OFS_EP_CTRL, 32'h007F_007F);
    repeat (2) @(posedge core_clk);
    `CHK("toggle", 7'h7F, toggle_sequence)
    pulse_tog(7'h01, 7'h05);
    `CHK("toggle", 7'h7A, toggle_sequence)
    repeat (2) @(posedge core_clk);
    `CHK("pending", 0, notes.size())
    finish_test();
  end
endmodule : testbench

// [tb/usbgc_host_model.sv]
// Behavioural model of the USB host: frame starts and bus resets
`timescale 1ns/1ns
module usbgc_host_model (
  input  wire logic             core_clk,
  output usbgc_pkg::usbgc_sof_t sof_out,
  output logic                  bus_reset
);
  // ---------------------------------------------------------------
  // Idle state
  // ---------------------------------------------------------------
  initial begin
    sof_out   = '0;
    bus_reset = 1'b0;
  end

  // One frame start; after it the frame lines stop carrying the value
  task automatic send_sof(input logic [10:0] frame, input logic bad);
    @(posedge core_clk);
    sof_out <= {1'b1, bad, frame};
    @(posedge core_clk);
    sof_out <= {1'b0, ~bad, ~frame};
  endtask : send_sof

  // Bus reset held as a level for a few cycles
  task automatic reset_bus(input int cycles);
    @(posedge core_clk);
    bus_reset <= 1'b1;
    repeat (cycles) @(posedge core_clk);
    bus_reset <= 1'b0;
  endtask : reset_bus
endmodule : usbgc_host_model
